// File: inc/fault_status_pkg.sv
/*
  Constants of the analog input fault and status block.
  Assumes a 16-channel front end with signed samples.
*/
`default_nettype none

package fault_status_pkg;

  localparam int NUM_CH = 16;
  localparam int SAMPLE_W = 16;
  localparam int ADDR_W = 12;
  localparam int NUM_ALARMS = 5;
  localparam int NUM_CFG = 7;
  localparam int STATUS_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] MODULE_FAULT_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] CHANNEL_FAULT_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] PACKED_OFS = 12'h00C;
  localparam logic [ADDR_W-1:0] UNLATCH_OFS = 12'h010;
  localparam logic [5:0] STATUS_PAGE = 6'h01;
  localparam logic [2:0] CFG_PAGE = 3'h1;

  // Control register fields
  localparam int CTRL_INT_MODE_BIT = 0;
  localparam int CTRL_WIRING_LSB = 1;
  localparam logic [1:0] WIRING_SE = 2'h0;
  localparam logic [1:0] WIRING_DIFF = 2'h1;
  localparam logic [1:0] WIRING_HSD = 2'h2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Active channels per wiring; also the word forced during calibration
  localparam logic [15:0] MASK_SE = 16'hFFFF;
  localparam logic [15:0] MASK_DIFF = 16'h00FF;
  localparam logic [15:0] MASK_HSD = 16'h000F;
  localparam logic [15:0] COMM_FAULT_WORD = 16'hFFFF;

  // Per-channel status word bits
  localparam int ST_CAL_ERR = 7;
  localparam int ST_UNDER = 6;
  localparam int ST_OVER = 5;
  localparam int ST_RATE = 4;
  localparam int ST_LOW = 3;
  localparam int ST_HIGH = 2;
  localparam int ST_LOW_LOW = 1;
  localparam int ST_HIGH_HIGH = 0;

  // Module fault word bits
  localparam int MF_ANY = 15;
  localparam int MF_CAL_BUSY = 10;
  localparam int MF_CAL_ERR = 9;

  // Packed integer-mode word: top positions of channel 0
  localparam int PACKED_UNDER_TOP = 31;
  localparam int PACKED_OVER_TOP = 30;

  // Config slots; alarm slots share the status bit index
  localparam int CFG_DEADBAND = 5;
  localparam int CFG_CTRL = 6;
  localparam int CFG_LATCH_BIT = 0;
  localparam int CFG_ENABLE_BIT = 1;
  localparam logic [15:0] CFG_HIGH_RST = 16'h7FFF;
  localparam logic [15:0] CFG_LOW_RST = 16'h8000;
  localparam logic [15:0] CFG_ZERO_RST = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  function automatic logic [15:0] cfg_reset(input int k);
    if (k == ST_HIGH_HIGH || k == ST_HIGH) return CFG_HIGH_RST;
    if (k == ST_LOW_LOW || k == ST_LOW) return CFG_LOW_RST;
    return CFG_ZERO_RST;
  endfunction

endpackage

`default_nettype wire

// File: hdl/analog_input_fault_status.sv
/*
  Fault and status words of a 16-channel analog input module, with an
  AXI4-Lite register slave. Assumes all inputs are synchronous to clk_in.

  // Function
  // [R1] Float mode: below or above range sets the channel fault bit.
  // [R2] Failed calibration sets channel bit 7 and module fault bit 9.
  // [R3] Float mode: below-range flag at or below minimum level.
  // [R4] Float mode: above-range flag at or above maximum level.
  // [R5] Rate alarm bit 4 over rate limit; latched until unlatch.
  // [R6] Low alarm bit 3: below low limit, held in deadband or latch.
  // [R7] High alarm bit 2: above high limit, held in deadband or latch.
  // [R8] Low-low alarm bit 1: below low-low limit, held in deadband or latch.
  // [R9] High-high alarm bit 0: above high-high limit, held in deadband or latch.
  // [R10] Float mode single-ended wiring: alarm bits 0 to 4 are not provided.
  // [R11] Module fault word: summary 15, calibrating 10, cal error 9, 11-14 unused.
  // [R12] Summary bit set whenever any channel fault bit is set.
  // [R13] Calibrating sets bit 10 and forces FFFF, 00FF or 000F by wiring.
  // [R14] Link failure to the owner forces the channel fault word to FFFF.
  // [R15] Channel n is fault bit n; 16, 8 or 4 channels by wiring.
  // [R16] Integer mode: one 32-bit word, range flags only, no alarms.
  // [R17] Packed word: below-range at bit 31-2n, above-range at 30-2n.
  // [R18] Integer mode still raises the module calibration error bit.
  // [R19] Integer mode: range condition sets that channel's fault bit.
  // [R20] Integer mode module bits 15-8 and channel word match float mode.
  // [R21] All words reevaluated at every sample update.
*/
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module analog_input_fault_status #(
  parameter int SAMPLE_W = fault_status_pkg::SAMPLE_W,
  parameter logic [SAMPLE_W-1:0] MIN_DETECT = 16'h8000,
  parameter logic [SAMPLE_W-1:0] MAX_DETECT = 16'h7FFF
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [fault_status_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [fault_status_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic sample_valid_in,
  input wire logic [fault_status_pkg::NUM_CH*SAMPLE_W-1:0] sample_data_in,
  input wire logic [fault_status_pkg::NUM_CH-1:0] cal_busy_in,
  input wire logic [fault_status_pkg::NUM_CH-1:0] cal_fail_in,
  input wire logic comm_fault_in,
  output logic [15:0] module_fault_out,
  output logic [15:0] channel_fault_out,
  output logic [31:0] packed_status_out,
  output logic [fault_status_pkg::NUM_CH*fault_status_pkg::STATUS_W-1:0] channel_status_out
);

  localparam int NCH = fault_status_pkg::NUM_CH;
  localparam int EW = SAMPLE_W + 2;
  localparam int SWW = fault_status_pkg::STATUS_W;

  // Bus registers
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // Software state
  logic [2:0] ctrl_ff;
  logic [NCH-1:0] unlatch_ff;
  logic [SAMPLE_W-1:0] cfg_ff [NCH][fault_status_pkg::NUM_CFG];

  // Fault state
  logic [NCH-1:0] below_ff;
  logic [NCH-1:0] above_ff;
  logic [NCH-1:0] cal_err_ff;
  logic [NCH-1:0] cal_busy_prev_ff;
  logic [15:0] module_fault_ff;
  logic [15:0] channel_fault_ff;
  logic [31:0] packed_ff;
  logic [NCH*SWW-1:0] status_ff;

  logic wr_fire;
  logic rd_fire;
  logic int_mode;
  logic [1:0] wiring;
  logic [15:0] active_mask;
  logic [15:0] nxt_channel_fault;
  logic [15:0] nxt_module_fault;
  logic [31:0] nxt_packed;
  logic [NCH*SWW-1:0] nxt_status;
  logic [NCH-1:0] nxt_below;
  logic [NCH-1:0] nxt_above;
  logic [fault_status_pkg::NUM_ALARMS-1:0] alarm [NCH];
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [3:0] wr_ch;
  logic [2:0] wr_slot;
  logic wr_cfg_hit;
  logic [15:0] wr_mask;

  assign wr_fire = s_axi_awvalid_in & awready_ff & s_axi_wvalid_in & wready_ff;
  assign rd_fire = s_axi_arvalid_in & arready_ff;
  assign int_mode = ctrl_ff[fault_status_pkg::CTRL_INT_MODE_BIT];
  assign wiring = ctrl_ff[fault_status_pkg::CTRL_WIRING_LSB +: 2];
  assign wr_ch = s_axi_awaddr_in[8:5];
  assign wr_slot = s_axi_awaddr_in[4:2];
  assign wr_cfg_hit = (s_axi_awaddr_in[11:9] == fault_status_pkg::CFG_PAGE) &&
                      (int'(wr_slot) < fault_status_pkg::NUM_CFG);
  assign wr_mask = {{8{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}};

  // Unused wiring code 3 is treated as the narrowest setting
  always_comb begin
    unique case (wiring)
      fault_status_pkg::WIRING_SE: active_mask = fault_status_pkg::MASK_SE;
      fault_status_pkg::WIRING_DIFF: active_mask = fault_status_pkg::MASK_DIFF;
      default: active_mask = fault_status_pkg::MASK_HSD;
    endcase
  end

  // Write channels: address and data are taken together on one edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      awready_ff <= s_axi_awvalid_in & s_axi_wvalid_in & ~awready_ff & ~bvalid_ff;
      wready_ff <= s_axi_awvalid_in & s_axi_wvalid_in & ~wready_ff & ~bvalid_ff;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= fault_status_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      if (s_axi_awaddr_in == fault_status_pkg::CTRL_OFS ||
          s_axi_awaddr_in == fault_status_pkg::UNLATCH_OFS || wr_cfg_hit) begin
        bresp_ff <= fault_status_pkg::RESP_OKAY;
      end else if (s_axi_awaddr_in == fault_status_pkg::MODULE_FAULT_OFS ||
                   s_axi_awaddr_in == fault_status_pkg::CHANNEL_FAULT_OFS ||
                   s_axi_awaddr_in == fault_status_pkg::PACKED_OFS ||
                   s_axi_awaddr_in[11:6] == fault_status_pkg::STATUS_PAGE) begin
        bresp_ff <= fault_status_pkg::RESP_SLVERR;
      end else begin
        bresp_ff <= fault_status_pkg::RESP_DECERR;
      end
    end else if (s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_ff <= fault_status_pkg::CTRL_RST;
    end else if (wr_fire && s_axi_wstrb_in[0] &&
                 s_axi_awaddr_in == fault_status_pkg::CTRL_OFS) begin
      ctrl_ff <= s_axi_wdata_in[2:0];
    end
  end

  // Unlatch is a one-cycle pulse per channel, never stored
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      unlatch_ff <= '0;
    end else if (wr_fire && s_axi_awaddr_in == fault_status_pkg::UNLATCH_OFS) begin
      unlatch_ff <= s_axi_wdata_in[15:0] & wr_mask;
    end else begin
      unlatch_ff <= '0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int c = 0; c < NCH; c++) begin
        for (int k = 0; k < fault_status_pkg::NUM_CFG; k++) begin
          cfg_ff[c][k] <= fault_status_pkg::cfg_reset(k);
        end
      end
    end else if (wr_fire && wr_cfg_hit) begin
      cfg_ff[wr_ch][wr_slot] <= (s_axi_wdata_in[15:0] & wr_mask) |
                                (cfg_ff[wr_ch][wr_slot] & ~wr_mask);
    end
  end

  // Read channel
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_resp = fault_status_pkg::RESP_OKAY;
    if (s_axi_araddr_in == fault_status_pkg::CTRL_OFS) begin
      rd_data = {29'h0000_0000, ctrl_ff};
    end else if (s_axi_araddr_in == fault_status_pkg::MODULE_FAULT_OFS) begin
      rd_data = {16'h0000, module_fault_ff};
    end else if (s_axi_araddr_in == fault_status_pkg::CHANNEL_FAULT_OFS) begin
      rd_data = {16'h0000, channel_fault_ff};
    end else if (s_axi_araddr_in == fault_status_pkg::PACKED_OFS) begin
      rd_data = packed_ff;
    end else if (s_axi_araddr_in == fault_status_pkg::UNLATCH_OFS) begin
      rd_data = 32'h0000_0000;
    end else if (s_axi_araddr_in[11:6] == fault_status_pkg::STATUS_PAGE) begin
      rd_data = {24'h00_0000, status_ff[s_axi_araddr_in[5:2]*SWW +: SWW]};
    end else if (s_axi_araddr_in[11:9] == fault_status_pkg::CFG_PAGE &&
                 int'(s_axi_araddr_in[4:2]) < fault_status_pkg::NUM_CFG) begin
      rd_data = {16'h0000, cfg_ff[s_axi_araddr_in[8:5]][s_axi_araddr_in[4:2]]};
    end else begin
      rd_resp = fault_status_pkg::RESP_DECERR;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arready_ff <= 1'b0;
    end else begin
      arready_ff <= s_axi_arvalid_in & ~arready_ff & ~rvalid_ff;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= fault_status_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data;
      rresp_ff <= rd_resp;
    end else if (s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Per-channel detection; state moves on a sample update, latched alarms also on an unlatch pulse
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic [SAMPLE_W-1:0] raw;
    logic [SAMPLE_W-1:0] prev_ff;
    logic [fault_status_pkg::NUM_ALARMS-1:0] alarm_ff;
    logic [fault_status_pkg::NUM_ALARMS-1:0] trip;
    logic [fault_status_pkg::NUM_ALARMS-1:0] keep;
    logic signed [EW-1:0] x;
    logic signed [EW-1:0] x_prev;
    logic signed [EW-1:0] slope;
    logic signed [EW-1:0] slope_abs;
    logic signed [EW-1:0] band;
    logic signed [EW-1:0] rate;
    logic signed [EW-1:0] lim [4];
    logic latch_en;
    logic alarm_en;

    assign raw = sample_data_in[ch*SAMPLE_W +: SAMPLE_W];
    assign x = {{2{raw[SAMPLE_W-1]}}, raw};
    assign x_prev = {{2{prev_ff[SAMPLE_W-1]}}, prev_ff};
    assign slope = x - x_prev;
    assign slope_abs = slope[EW-1] ? -slope : slope;
    assign band = {2'b00, cfg_ff[ch][fault_status_pkg::CFG_DEADBAND]};
    assign rate = {2'b00, cfg_ff[ch][fault_status_pkg::ST_RATE]};
    assign latch_en = cfg_ff[ch][fault_status_pkg::CFG_CTRL][fault_status_pkg::CFG_LATCH_BIT];
    assign alarm_en = cfg_ff[ch][fault_status_pkg::CFG_CTRL][fault_status_pkg::CFG_ENABLE_BIT];

    for (genvar k = 0; k < 4; k++) begin : g_lim
      assign lim[k] = {{2{cfg_ff[ch][k][SAMPLE_W-1]}}, cfg_ff[ch][k]};
    end

    // Wide arithmetic keeps limit plus or minus deadband from wrapping
    assign trip[fault_status_pkg::ST_HIGH_HIGH] = x > lim[0]; // see [R9]
    assign keep[fault_status_pkg::ST_HIGH_HIGH] = x > lim[0] - band; // see [R9]
    assign trip[fault_status_pkg::ST_LOW_LOW] = x < lim[1]; // see [R8]
    assign keep[fault_status_pkg::ST_LOW_LOW] = x < lim[1] + band; // see [R8]
    assign trip[fault_status_pkg::ST_HIGH] = x > lim[2]; // see [R7]
    assign keep[fault_status_pkg::ST_HIGH] = x > lim[2] - band; // see [R7]
    assign trip[fault_status_pkg::ST_LOW] = x < lim[3]; // see [R6]
    assign keep[fault_status_pkg::ST_LOW] = x < lim[3] + band; // see [R6]
    // A zero rate limit disables the rate alarm
    assign trip[fault_status_pkg::ST_RATE] = (rate != '0) && (slope_abs > rate); // see [R5]
    assign keep[fault_status_pkg::ST_RATE] = (rate != '0) && (slope_abs >= rate); // see [R5]

    // A new trip wins over an unlatch arriving in the same cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        alarm_ff <= '0;
      end else if (sample_valid_in) begin
        alarm_ff <= {fault_status_pkg::NUM_ALARMS{alarm_en}} &
                    (trip | (alarm_ff & (keep | {fault_status_pkg::NUM_ALARMS{
                     latch_en & ~unlatch_ff[ch]}}))); // see [R5] [R6] [R7] [R8] [R9] [R21]
      end else if (latch_en && unlatch_ff[ch]) begin
        alarm_ff <= alarm_ff & keep;
      end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        prev_ff <= '0;
      end else if (sample_valid_in) begin
        prev_ff <= raw;
      end
    end

    assign alarm[ch] = alarm_ff;
    assign nxt_below[ch] = x <= $signed({{2{MIN_DETECT[SAMPLE_W-1]}}, MIN_DETECT}); // see [R3]
    assign nxt_above[ch] = x >= $signed({{2{MAX_DETECT[SAMPLE_W-1]}}, MAX_DETECT}); // see [R4]

    // Alarm bits hidden on single-ended float wiring and in integer mode
    assign nxt_status[ch*SWW +: SWW] = int_mode ?
        {1'b0, below_ff[ch], above_ff[ch], 5'h00} : // see [R16]
        {cal_err_ff[ch], below_ff[ch], above_ff[ch],
         (wiring == fault_status_pkg::WIRING_SE) ? 5'h00 : alarm[ch]}; // see [R10] [R2]

    assign nxt_packed[fault_status_pkg::PACKED_UNDER_TOP - 2*ch] =
        below_ff[ch] & active_mask[ch]; // see [R17]
    assign nxt_packed[fault_status_pkg::PACKED_OVER_TOP - 2*ch] =
        above_ff[ch] & active_mask[ch]; // see [R17]
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      below_ff <= '0;
      above_ff <= '0;
    end else if (sample_valid_in) begin
      below_ff <= nxt_below; // see [R21]
      above_ff <= nxt_above; // see [R21]
    end
  end

  // A failure pulse wins over the clear at a calibration start
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cal_err_ff <= '0;
      cal_busy_prev_ff <= '0;
    end else begin
      cal_err_ff <= cal_fail_in | (cal_err_ff & ~(cal_busy_in & ~cal_busy_prev_ff)); // see [R2]
      cal_busy_prev_ff <= cal_busy_in;
    end
  end

  // Link failure beats calibration, which beats range
  always_comb begin
    if (comm_fault_in) begin
      nxt_channel_fault = fault_status_pkg::COMM_FAULT_WORD; // see [R14]
    end else if (|cal_busy_in) begin
      nxt_channel_fault = active_mask; // see [R13]
    end else begin
      nxt_channel_fault = (below_ff | above_ff) & active_mask; // see [R1] [R15] [R19] [R20]
    end
  end

  always_comb begin
    nxt_module_fault = 16'h0000; // see [R11]
    nxt_module_fault[fault_status_pkg::MF_ANY] = |nxt_channel_fault; // see [R12]
    nxt_module_fault[fault_status_pkg::MF_CAL_BUSY] = |cal_busy_in; // see [R13]
    nxt_module_fault[fault_status_pkg::MF_CAL_ERR] = |cal_err_ff; // see [R2] [R18] [R20]
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      module_fault_ff <= 16'h0000;
      channel_fault_ff <= 16'h0000;
      packed_ff <= 32'h0000_0000;
      status_ff <= '0;
    end else begin
      module_fault_ff <= nxt_module_fault;
      channel_fault_ff <= nxt_channel_fault;
      packed_ff <= int_mode ? nxt_packed : 32'h0000_0000; // see [R16]
      status_ff <= nxt_status;
    end
  end

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign module_fault_out = module_fault_ff;
  assign channel_fault_out = channel_fault_ff;
  assign packed_status_out = packed_ff;
  assign channel_status_out = status_ff;

endmodule // analog_input_fault_status

`default_nettype wire

// File: bench/analog_input_fault_status_asserts.sv
/* Assertions on the block's fault words; assumes a bind to the top ports. */
`timescale 1ns/1ns
`default_nettype none
module fault_status_checker #(
  parameter logic [15:0] MIN_DETECT = 16'h8000,
  parameter logic [15:0] MAX_DETECT = 16'h7FFF
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sample_valid_in,
  input wire logic [255:0] sample_data_in,
  input wire logic [15:0] cal_busy_in,
  input wire logic [15:0] cal_fail_in,
  input wire logic comm_fault_in,
  input wire logic [15:0] module_fault_out,
  input wire logic [15:0] channel_fault_out,
  input wire logic [31:0] packed_status_out
);
  logic [15:0] pair_any;
  always_comb begin
    for (int n = 0; n < 16; n++) begin
      pair_any[n] = packed_status_out[31-2*n] | packed_status_out[30-2*n];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_comm_word: assert property (comm_fault_in |=> channel_fault_out == 16'hFFFF)
    else $error("link fault word");
  a_cal_forced: assert property (|cal_busy_in && !comm_fault_in |=> module_fault_out[10]
    && channel_fault_out inside {16'hFFFF, 16'h00FF, 16'h000F})
    else $error("calibration word");
  a_summary_bit: assert property (module_fault_out[15] == (channel_fault_out != 16'h0000))
    else $error("summary bit");
  a_unused_bits: assert property ((module_fault_out & 16'h79FF) == 16'h0000)
    else $error("unused bits");
  a_cal_error: assert property (|cal_fail_in |-> ##2 module_fault_out[9])
    else $error("cal error");
  a_packed_pairs: assert property ((pair_any & ~channel_fault_out) == 16'h0000)
    else $error("packed flag");
  a_below_range: assert property (sample_valid_in &&
    $signed(sample_data_in[15:0]) <= $signed(MIN_DETECT) |-> ##2 channel_fault_out[0])
    else $error("below range");
  a_above_range: assert property (sample_valid_in &&
    $signed(sample_data_in[15:0]) >= $signed(MAX_DETECT) |-> ##2 channel_fault_out[0])
    else $error("above range");
endmodule // fault_status_checker
bind analog_input_fault_status fault_status_checker #(.MIN_DETECT(MIN_DETECT),
  .MAX_DETECT(MAX_DETECT)) checker_inst (.clk_in(clk_in), .resetn_in(resetn_in),
  .sample_valid_in(sample_valid_in), .sample_data_in(sample_data_in),
  .cal_busy_in(cal_busy_in), .cal_fail_in(cal_fail_in), .comm_fault_in(comm_fault_in),
  .module_fault_out(module_fault_out), .channel_fault_out(channel_fault_out),
  .packed_status_out(packed_status_out));
`default_nettype wire

// File: bench/owner_ctrl_model.sv
/* AXI4-Lite master standing in for the owner controller; same clock. */
`timescale 1ns/1ns
`default_nettype none
module owner_ctrl_model (
  input wire logic clk_in,
  output logic [11:0] awaddr_out, output logic awvalid_out, input wire logic awready_in,
  output logic [31:0] wdata_out, output logic [3:0] wstrb_out,
  output logic wvalid_out, input wire logic wready_in,
  input wire logic [1:0] bresp_in, input wire logic bvalid_in, output logic bready_out,
  output logic [11:0] araddr_out, output logic arvalid_out, input wire logic arready_in,
  input wire logic [31:0] rdata_in, input wire logic [1:0] rresp_in,
  input wire logic rvalid_in, output logic rready_out
);
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
    wstrb_out = 4'hF;
  end
  // Holds each channel until its own ready; gives up after 100 cycles
  task automatic xfer(input bit is_rd, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r, output bit ok);
    int n;
    n = 0;
    @(posedge clk_in);
    if (is_rd) begin
      araddr_out <= a;
      arvalid_out <= 1'b1;
      rready_out <= 1'b1;
    end else begin
      awaddr_out <= a;
      wdata_out <= d;
      awvalid_out <= 1'b1;
      wvalid_out <= 1'b1;
      bready_out <= 1'b1;
    end
    do begin
      @(posedge clk_in);
      n++;
      if (arvalid_out && arready_in) arvalid_out <= 1'b0;
      if (awvalid_out && awready_in) awvalid_out <= 1'b0;
      if (wvalid_out && wready_in) wvalid_out <= 1'b0;
    end while (!(is_rd ? rvalid_in : bvalid_in) && n < 100);
    q = rdata_in;
    r = is_rd ? rresp_in : bresp_in;
    ok = (n < 100);
    rready_out <= 1'b0;
    bready_out <= 1'b0;
  endtask
endmodule // owner_ctrl_model
`default_nettype wire

// File: bench/analog_input_fault_status_bench.sv
/* Bench with a word model; assumes the owner model drives the bus. */
`timescale 1ns/1ns
`default_nettype none
module analog_input_fault_status_bench;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, packed_status_out;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic sample_valid_in = 1'b0, comm_fault_in = 1'b0;
  logic [255:0] sample_data_in = 256'h0;
  logic [15:0] cal_busy_in = 16'h0000, cal_fail_in = 16'h0000;
  logic [15:0] module_fault_out, channel_fault_out, seed = 16'h002E, mask, calerr = 16'h0000;
  logic [15:0] smp [16];
  logic [127:0] channel_status_out;
  logic [2:0] modes [6] = '{3'h2, 3'h0, 3'h4, 3'h1, 3'h3, 3'h5};
  int miscompares = 0, total_checks = 0;
  bit int_mode;
  always #2 clk_in = ~clk_in;
  analog_input_fault_status analog_input_fault_status_inst (.clk_in(clk_in),
    .resetn_in(resetn_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .sample_valid_in(sample_valid_in), .sample_data_in(sample_data_in),
    .cal_busy_in(cal_busy_in), .cal_fail_in(cal_fail_in), .comm_fault_in(comm_fault_in),
    .module_fault_out(module_fault_out), .channel_fault_out(channel_fault_out),
    .packed_status_out(packed_status_out), .channel_status_out(channel_status_out));
  owner_ctrl_model owner_ctrl_model_inst (.clk_in(clk_in), .awaddr_out(awaddr),
    .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
    .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid),
    .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
    .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input bit rd, input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er, input logic [31:0] eq);
    logic [31:0] q;
    logic [1:0] r;
    bit ok;
    owner_ctrl_model_inst.xfer(rd, a, d, q, r, ok);
    if (!ok) begin
      miscompares++;
      end_sim();
    end
    chk("bus response", {30'h0, er}, {30'h0, r});
    if (rd) chk("read data", eq, q);
  endtask
  // Model of every word; ch0 high-high alarm armed at limit 1000
  task automatic check_all(output logic [15:0] chf);
    logic [15:0] rng;
    logic [31:0] pk;
    bit u, o, hh;
    rng = 16'h0000;
    pk = 32'h0;
    for (int n = 0; n < 16; n++) begin
      u = smp[n] == 16'h8000;
      o = smp[n] == 16'h7FFF;
      hh = n == 0 && !int_mode && mask != 16'hFFFF && $signed(smp[0]) > $signed(16'h1000);
      chk("status byte", {calerr[n] & ~int_mode, u, o, 4'h0, hh}, channel_status_out[8*n+:8]);
      rng[n] = u | o;
      pk[31-2*n] = u & mask[n];
      pk[30-2*n] = o & mask[n];
    end
    chf = comm_fault_in ? 16'hFFFF : (|cal_busy_in ? mask : rng & mask);
    chk("channel fault", chf, channel_fault_out);
    chk("module fault", {chf != 0, 4'h0, |cal_busy_in, |calerr, 9'h0}, module_fault_out);
    chk("packed status", int_mode ? pk : 32'h0, packed_status_out);
  endtask
  initial begin
    logic [15:0] chf;
    smp = '{default: 16'h0000};
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    bus(1, 12'h000, 0, 2'h0, 32'h0);
    bus(1, 12'hFFC, 0, 2'h3, 32'h0);
    bus(0, 12'h004, 0, 2'h2, 32'h0);
    bus(0, 12'h200, 32'h1000, 2'h0, 32'h0);
    bus(0, 12'h218, 32'h2, 2'h0, 32'h0);
    for (int m = 0; m < 6; m++) begin
      int_mode = modes[m][0];
      mask = modes[m][2] ? 16'h000F : (modes[m][1] ? 16'h00FF : 16'hFFFF);
      bus(0, 12'h000, modes[m], 2'h0, 32'h0);
      bus(1, 12'h000, 0, 2'h0, {29'h0, modes[m]});
      for (int i = 0; i < 12; i++) begin
        // Two samples back to back: only the second may show
        repeat (2) begin
          for (int n = 0; n < 16; n++) begin
            seed = lfsr(seed);
            smp[n] = seed[1:0] == 2'h0 ? 16'h8000 : (seed[1:0] == 2'h1 ? 16'h7FFF : seed);
          end
          @(posedge clk_in);
          sample_valid_in <= 1'b1;
          for (int n = 0; n < 16; n++) sample_data_in[16*n+:16] <= smp[n];
        end
        @(posedge clk_in);
        sample_valid_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check_all(chf);
      end
      bus(1, 12'h008, 0, 2'h0, {16'h0, chf});
      @(posedge clk_in);
      cal_busy_in[2*m] <= 1'b1;
      calerr[2*m] = 1'b0;
      repeat (3) @(posedge clk_in);
      check_all(chf);
      cal_fail_in[2*m] <= 1'b1;
      cal_busy_in[2*m] <= 1'b0;
      @(posedge clk_in);
      cal_fail_in[2*m] <= 1'b0;
      calerr[2*m] = 1'b1;
      comm_fault_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      check_all(chf);
      comm_fault_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check_all(chf);
    end
    end_sim();
  end
endmodule // analog_input_fault_status_bench
`default_nettype wire
